// *** rtl/timer_pin_io_mode_select.sv ***
// Purpose: Pin I/O mode decode, compare output and input capture for the
//          channel-3 D and channel-4 B general registers.
// Assumes: Counters, count pulse and channel-3 C events come from outside,
//          synchronous to clk; pin inputs are synchronous to clk.
// Notes:   Register reads take one wait state, writes none.
`timescale 1ns/10ps
`default_nettype none

module timer_pin_io_mode_select (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [15:0] ch3_counter,
    input  wire logic [15:0] ch4_counter,
    input  wire logic        ch4_count_pulse,
    input  wire logic        ch3_c_event,
    input  wire logic        ch3_d_timer_pin_in,
    output logic             ch3_d_timer_pin_out,
    output logic             ch3_d_timer_pin_oe_n,
    input  wire logic        ch4_b_timer_pin_in,
    output logic             ch4_b_timer_pin_out,
    output logic             ch4_b_timer_pin_oe_n,
    output logic             irq
);

    // ---------------------------------------------------------------
    // Mode decode helpers
    // ---------------------------------------------------------------
    function automatic logic mode_is_capture(input logic [3:0] mode);
        mode_is_capture = mode[3];
    endfunction

    function automatic logic pin_capture_hit(input logic [3:0] mode,
                                             input logic       rise,
                                             input logic       fall);
        logic use_pin;
        logic on_rise;
        logic on_fall;
        use_pin = mode[3] && !mode[2];
        on_rise = mode[1] || !mode[0];
        on_fall = mode[1] || mode[0];
        pin_capture_hit = use_pin && ((rise && on_rise) || (fall && on_fall));
    endfunction

    // ---------------------------------------------------------------
    // Bus slave
    // ---------------------------------------------------------------
    logic [timer_pin_io_pkg::ADDR_W-1:0] addr_ff;
    logic                                wr_pend_ff;
    logic                                rd_pend_ff;
    logic                                hreadyout_ff;
    logic [31:0]                         hrdata_ff;
    logic [31:0]                         rd_data;
    logic [3:0]                          aux_ff;
    logic [timer_pin_io_pkg::EVT_W-1:0]  status_ff;
    logic [timer_pin_io_pkg::EVT_W-1:0]  enable_ff;
    logic                                irq_ff;
    logic [timer_pin_io_pkg::EVT_W-1:0]  evt;
    logic [timer_pin_io_pkg::EVT_W-1:0]  nxt_status;
    logic [timer_pin_io_pkg::EVT_W-1:0]  clr_bits;

    wire addr_ok    = hsel && htrans[1] && hready;
    wire wr_aux     = wr_pend_ff && (addr_ff == timer_pin_io_pkg::OFS_AUX_CTRL);
    wire wr_clear   = wr_pend_ff && (addr_ff == timer_pin_io_pkg::OFS_IRQ_CLEAR);
    wire wr_enable  = wr_pend_ff && (addr_ff == timer_pin_io_pkg::OFS_IRQ_ENABLE);
    wire buf_mode   = aux_ff[timer_pin_io_pkg::AUX_BUF_BIT];
    wire [2:0] psc  = aux_ff[timer_pin_io_pkg::AUX_PSC_MSB:timer_pin_io_pkg::AUX_PSC_LSB];
    wire psc_ok     = (psc != timer_pin_io_pkg::PSC_UNDIVIDED);
    wire irq_nxt    = |(nxt_status & enable_ff);

    // Only whole-word transfers are issued, so the size is not decoded
    wire unused_ok  = &{1'b0, hsize, haddr[31:timer_pin_io_pkg::ADDR_W]};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_ff      <= '0;
            wr_pend_ff   <= 1'b0;
            rd_pend_ff   <= 1'b0;
            hreadyout_ff <= 1'b1;
            hrdata_ff    <= 32'h0000_0000;
        end else begin
            if (addr_ok) begin
                addr_ff <= haddr[timer_pin_io_pkg::ADDR_W-1:0];
            end
            wr_pend_ff   <= addr_ok && hwrite;
            rd_pend_ff   <= addr_ok && !hwrite;
            // A wait state on reads covers the cycle hrdata_ff takes to register rd_data
            hreadyout_ff <= !(addr_ok && !hwrite);
            if (rd_pend_ff) begin
                hrdata_ff <= rd_data;
            end
        end
    end

    assign hrdata    = hrdata_ff;
    assign hreadyout = hreadyout_ff;
    assign hresp     = unused_ok;

    // ---------------------------------------------------------------
    // Per-channel compare and capture
    // ---------------------------------------------------------------
    logic [1:0]                          pin_out;
    logic [1:0]                          pin_oe_n;
    logic [7:0]                          ioctl_rd [timer_pin_io_pkg::NUM_CH];
    logic [timer_pin_io_pkg::CNT_W-1:0]  gr_rd    [timer_pin_io_pkg::NUM_CH];

    genvar c;
    generate
        for (c = 0; c < timer_pin_io_pkg::NUM_CH; c++) begin : g_ch
            logic [7:0]                         ioctl_ff;
            logic [timer_pin_io_pkg::CNT_W-1:0] gr_ff;
            logic                               lvl_ff;
            logic                               oe_n_ff;
            logic                               eq_ff;
            logic                               pin_prev_ff;
            logic                               nxt_lvl;
            logic [7:0]                         ofs_ioctl;
            logic [7:0]                         ofs_gr;
            logic [timer_pin_io_pkg::CNT_W-1:0] cnt;
            logic                               pin_in;
            logic                               special_evt;
            logic                               valid;

            if (c == 0) begin : g_d3
                assign ofs_ioctl   = timer_pin_io_pkg::OFS_CH3_IOCTL;
                assign ofs_gr      = timer_pin_io_pkg::OFS_CH3_GR_D;
                assign cnt         = ch3_counter;
                assign pin_in      = ch3_d_timer_pin_in;
                assign special_evt = ch4_count_pulse && psc_ok;
                assign valid       = !buf_mode;
            end else begin : g_b4
                assign ofs_ioctl   = timer_pin_io_pkg::OFS_CH4_IOCTL;
                assign ofs_gr      = timer_pin_io_pkg::OFS_CH4_GR_B;
                assign cnt         = ch4_counter;
                assign pin_in      = ch4_b_timer_pin_in;
                assign special_evt = ch3_c_event;
                assign valid       = 1'b1;
            end

            wire [3:0] mode     = ioctl_ff[timer_pin_io_pkg::MODE_MSB:timer_pin_io_pkg::MODE_LSB];
            wire [3:0] new_mode = hwdata[timer_pin_io_pkg::MODE_MSB:timer_pin_io_pkg::MODE_LSB];
            wire [1:0] act      = mode[1:0];
            wire wr_ioctl  = wr_pend_ff && (addr_ff == ofs_ioctl);
            wire wr_gr     = wr_pend_ff && (addr_ff == ofs_gr);
            wire is_cap    = mode_is_capture(mode);
            wire eq        = (cnt == gr_ff);
            // One match per counter arrival at the value, even when it dwells
            wire cmp_evt   = valid && !is_cap && eq && !eq_ff;
            wire rise      = pin_in && !pin_prev_ff;
            wire fall      = !pin_in && pin_prev_ff;
            wire sp_hit    = is_cap && mode[2] && special_evt;
            wire cap_evt   = valid && (pin_capture_hit(mode, rise, fall) || sp_hit);
            wire drive_nxt = valid && !new_mode[3] && (new_mode[1:0] != timer_pin_io_pkg::ACT_NONE);
            wire drive_now = valid && !is_cap && (act != timer_pin_io_pkg::ACT_NONE);

            always_comb begin
                nxt_lvl = lvl_ff;
                if (wr_ioctl && !new_mode[3]) begin
                    nxt_lvl = new_mode[2];
                end else if (cmp_evt) begin
                    case (act)
                        timer_pin_io_pkg::ACT_LOW:    nxt_lvl = 1'b0;
                        timer_pin_io_pkg::ACT_HIGH:   nxt_lvl = 1'b1;
                        timer_pin_io_pkg::ACT_TOGGLE: nxt_lvl = !lvl_ff;
                        default:                      nxt_lvl = lvl_ff;
                    endcase
                end
            end

            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    ioctl_ff    <= timer_pin_io_pkg::IOCTL_RST;
                    gr_ff       <= timer_pin_io_pkg::GR_RST;
                    lvl_ff      <= 1'b0;
                    oe_n_ff     <= 1'b1;
                    eq_ff       <= 1'b0;
                    pin_prev_ff <= 1'b0;
                end else begin
                    if (wr_ioctl) begin
                        ioctl_ff <= hwdata[7:0];
                    end
                    // Capture beats a software write in the same cycle
                    if (cap_evt) begin
                        gr_ff <= cnt;
                    end else if (wr_gr) begin
                        gr_ff <= hwdata[timer_pin_io_pkg::CNT_W-1:0];
                    end
                    lvl_ff      <= nxt_lvl;
                    // Output disabled for 0x00 and 0x40, capture, and an invalid D field
                    oe_n_ff     <= wr_ioctl ? !drive_nxt : !drive_now;
                    eq_ff       <= eq;
                    pin_prev_ff <= pin_in;
                end
            end

            assign evt[2*c + timer_pin_io_pkg::EVT_CMP_OFS] = cmp_evt;
            assign evt[2*c + timer_pin_io_pkg::EVT_CAP_OFS] = cap_evt;
            assign pin_out[c]  = lvl_ff;
            assign pin_oe_n[c] = oe_n_ff;
            assign ioctl_rd[c] = ioctl_ff;
            assign gr_rd[c]    = gr_ff;
        end
    endgenerate

    assign ch3_d_timer_pin_out  = pin_out[0];
    assign ch3_d_timer_pin_oe_n = pin_oe_n[0];
    assign ch4_b_timer_pin_out  = pin_out[1];
    assign ch4_b_timer_pin_oe_n = pin_oe_n[1];

    // ---------------------------------------------------------------
    // Event status and interrupt
    // ---------------------------------------------------------------
    assign clr_bits   = wr_clear ? hwdata[timer_pin_io_pkg::EVT_W-1:0] : '0;
    // A new event wins over a clear in the same cycle
    assign nxt_status = (status_ff & ~clr_bits) | evt;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aux_ff    <= timer_pin_io_pkg::AUX_RST;
            status_ff <= timer_pin_io_pkg::EVT_RST;
            enable_ff <= timer_pin_io_pkg::EVT_RST;
            irq_ff    <= 1'b0;
        end else begin
            if (wr_aux) begin
                aux_ff <= hwdata[3:0];
            end
            if (wr_enable) begin
                enable_ff <= hwdata[timer_pin_io_pkg::EVT_W-1:0];
            end
            status_ff <= nxt_status;
            irq_ff    <= irq_nxt;
        end
    end

    assign irq = irq_ff;

    // ---------------------------------------------------------------
    // Read mux
    // ---------------------------------------------------------------
    wire sel_ioctl3 = (addr_ff == timer_pin_io_pkg::OFS_CH3_IOCTL);
    wire sel_ioctl4 = (addr_ff == timer_pin_io_pkg::OFS_CH4_IOCTL);
    wire sel_aux    = (addr_ff == timer_pin_io_pkg::OFS_AUX_CTRL);
    wire sel_gr3    = (addr_ff == timer_pin_io_pkg::OFS_CH3_GR_D);
    wire sel_gr4    = (addr_ff == timer_pin_io_pkg::OFS_CH4_GR_B);
    wire sel_stat   = (addr_ff == timer_pin_io_pkg::OFS_IRQ_STATUS);
    wire sel_en     = (addr_ff == timer_pin_io_pkg::OFS_IRQ_ENABLE);
    wire sel_pins   = (addr_ff == timer_pin_io_pkg::OFS_PIN_STATE);

    // Clear register is write-only and unmapped offsets read zero
    assign rd_data = ({32{sel_ioctl3}} & {24'h00_0000, ioctl_rd[0]})
                   | ({32{sel_ioctl4}} & {24'h00_0000, ioctl_rd[1]})
                   | ({32{sel_aux}}    & {28'h000_0000, aux_ff})
                   | ({32{sel_gr3}}    & {16'h0000, gr_rd[0]})
                   | ({32{sel_gr4}}    & {16'h0000, gr_rd[1]})
                   | ({32{sel_stat}}   & {28'h000_0000, status_ff})
                   | ({32{sel_en}}     & {28'h000_0000, enable_ff})
                   | ({32{sel_pins}}   & {28'h000_0000, pin_oe_n, pin_out});

endmodule

`default_nettype wire

// *** include/timer_pin_io_pkg.sv ***
// Purpose: Constants for the timer pin I/O mode block.
// Assumes: AHB-Lite register bus, 32-bit data, one word per register.
// Notes:   Index 0 is the channel-3 D register path, index 1 the channel-4 B path.
package timer_pin_io_pkg;
    localparam int          NUM_CH         = 2;
    localparam int          CNT_W          = 16;
    localparam int          ADDR_W         = 8;
    localparam int          EVT_W          = 2 * NUM_CH;

    // ---------------------------------------------------------------
    // Register byte offsets
    // ---------------------------------------------------------------
    localparam logic [7:0]  OFS_CH3_IOCTL  = 8'h00;
    localparam logic [7:0]  OFS_CH4_IOCTL  = 8'h04;
    localparam logic [7:0]  OFS_AUX_CTRL   = 8'h08;
    localparam logic [7:0]  OFS_CH3_GR_D   = 8'h0c;
    localparam logic [7:0]  OFS_CH4_GR_B   = 8'h10;
    localparam logic [7:0]  OFS_IRQ_STATUS = 8'h14;
    localparam logic [7:0]  OFS_IRQ_CLEAR  = 8'h18;
    localparam logic [7:0]  OFS_IRQ_ENABLE = 8'h1c;
    localparam logic [7:0]  OFS_PIN_STATE  = 8'h20;

    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int          MODE_MSB       = 7;
    localparam int          MODE_LSB       = 4;
    localparam int          AUX_BUF_BIT    = 0;
    localparam int          AUX_PSC_LSB    = 1;
    localparam int          AUX_PSC_MSB    = 3;
    localparam int          EVT_CMP_OFS    = 0;
    localparam int          EVT_CAP_OFS    = 1;

    // ---------------------------------------------------------------
    // Encodings and reset values
    // ---------------------------------------------------------------
    localparam logic [2:0]  PSC_UNDIVIDED  = 3'h0;
    localparam logic [1:0]  ACT_NONE       = 2'h0;
    localparam logic [1:0]  ACT_LOW        = 2'h1;
    localparam logic [1:0]  ACT_HIGH       = 2'h2;
    localparam logic [1:0]  ACT_TOGGLE     = 2'h3;
    localparam logic [7:0]  IOCTL_RST      = 8'h00;
    localparam logic [3:0]  AUX_RST        = 4'h0;
    localparam logic [15:0] GR_RST         = 16'hffff;
    localparam logic [3:0]  EVT_RST        = 4'h0;
endpackage

// *** dv/timer_pin_ext_model.sv ***
// Purpose: Far side of the two timer pins: external drivers sharing each wire.
// Assumes: Pins are synchronous to clk; no pull resistors on either wire.
// Notes:   While the block drives a pin, the wire follows the block; otherwise the far side.
`timescale 1ns/10ps
`default_nettype none

module timer_pin_ext_model (
    input  wire logic d_level,
    input  wire logic b_level,
    input  wire logic d_out,
    input  wire logic d_oe_n,
    input  wire logic b_out,
    input  wire logic b_oe_n,
    output logic      d_in,
    output logic      b_in
);
    // The far side yields whenever the block drives, so the wire never fights
    assign d_in = d_oe_n ? d_level : d_out;
    assign b_in = b_oe_n ? b_level : b_out;
endmodule

`default_nettype wire

// *** dv/timer_pin_io_mode_select_props.sv ***
// Purpose: Port-level checks for the timer pin I/O mode block.
// Assumes: hready is the block's own hreadyout; one clock domain.
// Notes:   Internal registers are unseen, so pin checks key off io control writes.
`timescale 1ns/10ps
`default_nettype none

module timer_pin_io_mode_select_props (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        ch4_b_timer_pin_out,
    input wire logic        ch4_b_timer_pin_oe_n,
    input wire logic        irq
);
    wire logic take   = hsel && htrans[1] && hready;
    wire logic rd_take = take && !hwrite;
    wire logic io4_wr = take && hwrite && haddr[7:0] == timer_pin_io_pkg::OFS_CH4_IOCTL;
    wire logic ena_wr = take && hwrite && haddr[7:0] == timer_pin_io_pkg::OFS_IRQ_ENABLE;

    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    bus_okay_a: assert property (hresp == 1'b0)
        else $error("bus response not okay");
    read_wait_a: assert property (rd_take |=> !hreadyout ##1 hreadyout)
        else $error("read did not take exactly one wait");
    write_nowait_a: assert property (take && hwrite |=> hreadyout)
        else $error("write was stalled");
    stall_cause_a: assert property ($fell(hreadyout) |-> $past(rd_take))
        else $error("stall without a read");
    init_level_a: assert property (io4_wr ##1 (!hwdata[7] && hwdata[5:4] != 2'h0)
        |=> !ch4_b_timer_pin_oe_n && ch4_b_timer_pin_out == $past(hwdata[6]))
        else $error("compare code gave wrong initial pin");
    out_off_a: assert property (io4_wr ##1 (hwdata[7] || hwdata[5:4] == 2'h0)
        |=> ch4_b_timer_pin_oe_n)
        else $error("pin driven while output disabled");
    drive_cause_a: assert property ($fell(ch4_b_timer_pin_oe_n) |-> $past(io4_wr, 2))
        else $error("pin drive began without io control write");
    irq_masked_a: assert property (ena_wr ##1 (hwdata[3:0] == 4'h0) |-> ##2 !irq)
        else $error("interrupt high with all sources disabled");

    cover property (rd_take);
    cover property ($rose(irq));
    cover property ($fell(ch4_b_timer_pin_oe_n));
endmodule

`default_nettype wire

// *** dv/timer_pin_io_mode_select_test.sv ***
// Purpose: Self-checking bench for the timer pin I/O mode block.
// Assumes: Reads are checked by a monitor that pops the noted expectation.
// Notes:   Masks restrict a read check to the bits a scenario controls.
`timescale 1ns/10ps
`default_nettype none

module timer_pin_io_mode_select_test;
    localparam logic [7:0] IO3 = timer_pin_io_pkg::OFS_CH3_IOCTL;
    localparam logic [7:0] IO4 = timer_pin_io_pkg::OFS_CH4_IOCTL;
    localparam logic [7:0] AUX = timer_pin_io_pkg::OFS_AUX_CTRL;
    localparam logic [7:0] GRD = timer_pin_io_pkg::OFS_CH3_GR_D;
    localparam logic [7:0] GRB = timer_pin_io_pkg::OFS_CH4_GR_B;
    localparam logic [7:0] STA = timer_pin_io_pkg::OFS_IRQ_STATUS;
    localparam logic [7:0] CLR = timer_pin_io_pkg::OFS_IRQ_CLEAR;
    localparam logic [7:0] ENA = timer_pin_io_pkg::OFS_IRQ_ENABLE;
    localparam logic [7:0] PIN = timer_pin_io_pkg::OFS_PIN_STATE;
    logic        clk = 1'b0, rst_n = 1'b0, hwrite = 1'b0, cpulse = 1'b0, cev = 1'b0;
    logic        lvl_d = 1'b0, lvl_b = 1'b0, rd_ph = 1'b0, lv;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, seed = 32'hfe378edb, hrdata;
    logic [15:0] cnt3 = 16'h0, cnt4 = 16'h0, g, r;
    logic        hreadyout, hresp, irq, d_in, d_out, d_oe_n, b_in, b_out, b_oe_n;
    logic [31:0] exp_q[$], msk_q[$];
    int          n_mismatch = 0, n_compared = 0;

    always #5 clk = ~clk;

    timer_pin_io_mode_select dut (.clk, .rst_n, .hsel(1'b1), .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .ch3_counter(cnt3), .ch4_counter(cnt4), .ch4_count_pulse(cpulse), .ch3_c_event(cev),
        .ch3_d_timer_pin_in(d_in), .ch3_d_timer_pin_out(d_out), .ch3_d_timer_pin_oe_n(d_oe_n),
        .ch4_b_timer_pin_in(b_in), .ch4_b_timer_pin_out(b_out), .ch4_b_timer_pin_oe_n(b_oe_n),
        .irq);
    timer_pin_ext_model pins (.d_level(lvl_d), .b_level(lvl_b), .d_out, .d_oe_n, .b_out,
        .b_oe_n, .d_in, .b_in);

    // ---------------------------------------------------------------
    // Bus master, read monitor and verdict
    // ---------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, mk);
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= w ? d : rnd();
        if (!w) begin
            exp_q.push_back(d);
            msk_q.push_back(mk);
        end
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(a, 1'b1, d, 32'h0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, mk);
        bus(a, 1'b0, d, mk);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // One-cycle event strobe: count pulse when to_cnt is set, else the C event
    task automatic pulse(input logic to_cnt);
        if (to_cnt) begin
            cpulse <= 1'b1;
        end else begin
            cev <= 1'b1;
        end
        @(posedge clk);
        cpulse <= 1'b0;
        cev <= 1'b0;
        tick(2);
    endtask
    task automatic chk_irq(input logic x);
        #1;
        n_compared++;
        if (irq !== x) begin
            n_mismatch++;
            $display("Error t=%0t got %h expected %h", $time, irq, x);
        end
        @(posedge clk);
    endtask
    task automatic give_verdict();
        $display("Compared %0d, mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        if (rd_ph && hreadyout && exp_q.size() > 0) begin
            n_compared++;
            if (((hrdata ^ exp_q[0]) & msk_q[0]) !== 32'h0) begin
                n_mismatch++;
                $display("Error t=%0t got %h expected %h", $time, hrdata, exp_q[0]);
            end
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
        end
        rd_ph <= hreadyout ? (htrans[1] && !hwrite) : rd_ph;
    end
    initial begin
        #300000;
        n_mismatch++;
        give_verdict();
    end

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    initial begin
        tick(8);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(IO4, 32'h0, '1);
        rd(GRB, 32'hffff, '1);
        rd(PIN, 32'hc, '1);
        wr(8'h3c, rnd());
        rd(8'h3c, 32'h0, '1);
        rd(CLR, 32'h0, '1);
        for (int c = 0; c < 8; c++) begin
            r = 16'(rnd()) | 16'h1;
            cnt4 <= 16'h0;
            wr(GRB, {16'h0, r});
            wr(IO4, {24'h0, 4'(c), 4'h0});
            lv = c[2];
            rd(PIN, {28'h0, c[1:0] == 2'h0, 2'b0, 1'b0} | {30'h0, lv, 1'b0}, 32'ha);
            cnt4 <= r;
            tick(3);
            lv = c[1:0] == 2'h1 ? 1'b0 : c[1:0] == 2'h2 ? 1'b1 : c[1:0] == 2'h3 ? ~lv : lv;
            rd(PIN, {28'h0, c[1:0] == 2'h0, 1'b0, lv, 1'b0}, 32'ha);
            rd(STA, 32'h4, 32'h4);
            wr(CLR, 32'hf);
        end
        for (int c = 8; c < 12; c++) begin
            lvl_b <= 1'b0;
            wr(IO4, {24'h0, 4'(c), 4'h0});
            wr(GRB, 32'h0);
            g = 16'h0;
            for (int k = 0; k < 2; k++) begin
                r = 16'(rnd());
                cnt4 <= r;
                lvl_b <= ~k[0];
                tick(3);
                if ((k == 0 && c != 9) || (k == 1 && c != 8)) g = r;
                rd(GRB, {16'h0, g}, '1);
            end
        end
        wr(ENA, 32'h0);
        wr(IO4, 32'hc0);
        r = 16'(rnd());
        cnt4 <= r;
        lvl_b <= 1'b1;
        tick(3);
        rd(GRB, {16'h0, g}, '1);
        pulse(1'b0);
        rd(GRB, {16'h0, r}, '1);
        rd(STA, 32'h8, 32'h8);
        chk_irq(1'b0);
        wr(ENA, 32'h8);
        tick(2);
        chk_irq(1'b1);
        wr(CLR, 32'h8);
        tick(2);
        chk_irq(1'b0);
        rd(STA, 32'h0, 32'h8);
        wr(AUX, 32'h2);
        wr(IO3, 32'h50);
        rd(PIN, 32'h1, 32'h5);
        wr(IO3, 32'h80);
        wr(GRD, 32'h0);
        g = 16'(rnd());
        cnt3 <= g;
        lvl_d <= 1'b1;
        tick(3);
        rd(GRD, {16'h0, g}, '1);
        wr(IO3, 32'hc0);
        for (int a = 0; a < 3; a++) begin
            wr(AUX, a == 0 ? 32'h2 : a == 1 ? 32'h0 : 32'h3);
            r = 16'(rnd());
            cnt3 <= r;
            pulse(1'b1);
            if (a == 0) g = r;
            rd(GRD, {16'h0, g}, '1);
        end
        wr(IO3, 32'h10);
        rd(PIN, 32'h4, 32'h4);
        give_verdict();
    end
endmodule

bind timer_pin_io_mode_select timer_pin_io_mode_select_props props (.clk, .rst_n, .hsel,
    .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .ch4_b_timer_pin_out,
    .ch4_b_timer_pin_oe_n, .irq);

`default_nettype wire
